// ### verilog/ubr_pkg.sv
// Package for the serial bridge core: register map, field layout,
// timing constants, pin function codes and bus carriers.
// Assumes a single 100 MHz clock and a plain register port.
package ubr_pkg;

   // Clock and time base
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_OUT_30_HZ = 30_000_000;
   localparam int CLK_OUT_15_HZ = 15_000_000;
   localparam int CLK_OUT_7_HZ = 7_500_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int LED_MS = 10;
   localparam int LED_CYCLES = LED_MS * MS_CYCLES;

   // Sizes
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int BUF_DEPTH = 1024;
   localparam int AUX_PINS = 11;
   localparam int INT_W = 14;
   localparam int FRAC_W = 4;

   // Register indices
   localparam logic [4:0] REG_BAUD_INT = 5'h00;
   localparam logic [4:0] REG_BAUD_FRAC = 5'h01;
   localparam logic [4:0] REG_CTRL = 5'h02;
   localparam logic [4:0] REG_EE_MODE = 5'h03;
   localparam logic [4:0] REG_LATENCY = 5'h04;
   localparam logic [4:0] REG_GPIO_OUT = 5'h05;
   localparam logic [4:0] REG_GPIO_DIR = 5'h06;
   localparam logic [4:0] REG_STATUS = 5'h07;
   localparam logic [4:0] REG_PIN_IN = 5'h08;
   localparam logic [4:0] REG_TX_LEVEL = 5'h09;
   localparam logic [4:0] REG_RX_LEVEL = 5'h0a;
   localparam logic [4:0] REG_AUX_BASE = 5'h10;

   // Reset values and field positions
   localparam logic [13:0] BAUD_INT_RST = 14'h001a;
   localparam logic [7:0] LATENCY_RST = 8'h10;
   localparam int CTRL_X10 = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int MODE_W = 3;
   localparam int OS_X16 = 16;
   localparam int OS_X10 = 10;

   // Interface modes; UART is the zero code
   typedef enum logic [2:0] {
      UBR_MODE_UART, UBR_MODE_FIFO, UBR_MODE_PAR_SERIAL,
      UBR_MODE_FAST_SERIAL, UBR_MODE_CPU_FIFO,
      UBR_MODE_BITBANG, UBR_MODE_SERIAL_ENGINE
   } ubr_mode_e;

   // Auxiliary pin functions
   typedef enum logic [3:0] {
      UBR_AUX_INPUT_PULLUP_UNUSED, UBR_AUX_DRIVE_ENABLE,
      UBR_AUX_POWER_ENABLE, UBR_AUX_TX_LED, UBR_AUX_RX_LED,
      UBR_AUX_TXRX_LED, UBR_AUX_SLEEP, UBR_AUX_CLK_THIRTY,
      UBR_AUX_CLK_FIFTEEN, UBR_AUX_CLK_SEVEN_HALF,
      UBR_AUX_DRIVE_HIGH, UBR_AUX_DRIVE_LOW, UBR_AUX_GPIO
   } ubr_aux_e;

   // Register port request
   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } ubr_req_s;

   // Auxiliary pin bundle
   typedef struct packed {
      logic [10:0] value;
      logic [10:0] oe;
   } ubr_aux_s;

endpackage

// ### verilog/ubr_core.sv
// Serial bridge core: baud generator, UART, 1 KB buffers,
// latency flush and eleven function-selectable auxiliary pins.
// Assumes all inputs are synchronous to clk; the USB engine sits
// on the host stream side and a line transceiver on txd/rxd.
//
// Functional notes
// [R1] Oversample tick at x16 or x10
// [R2] Divisor: 14-bit integer plus 4-bit fraction
// [R3] Bit rate from 183 baud to 12 Mbaud; at 100 MHz the code spans about 381 baud (x16) to 10 Mbaud (x10)
// [R4] Rates 7, 9, 10, 11 Mbaud unsupported; the code has no special case for them
// [R5] 1 KB transmit buffer feeds the UART
// [R6] 1 KB receive buffer, returned on request
// [R7] Latency timeout flushes short receive packets
// [R8] Drive enable only while character shifts
// [R9] Power enable off during suspend
// [R10] Activity LEDs pulse low on traffic
// [R11] Sleep pin low entering suspend
// [R12] Clock output at 30, 15, 7.5 MHz; the code divides the 100 MHz clock by 2, 6 and 12
// [R13] Pins: unused input, drive high, drive low
// [R14] Eleven pins, one function each
// [R15] Pins usable as GPIO beside UART
// [R16] Configured interface mode, UART default
// [R17] Configuration memory uses 16-bit words
// [R18] Power-on and external active-low reset
// [R19] Host command switches controller mode
// [R20] Enable before start, after last stop
`timescale 1ns/100ps
`default_nettype none

module ubr_core #(
   parameter int MS_CYC = ubr_pkg::MS_CYCLES,
   parameter int LED_CYC = ubr_pkg::LED_CYCLES,
   parameter int DEPTH = ubr_pkg::BUF_DEPTH
) (
   // Clock, enable, resets
   input wire logic clk,
   input wire logic clk_en,
   input wire logic reset,
   input wire logic ext_reset_n,
   // Register port
   input wire ubr_pkg::ubr_req_s bus_req,
   output logic [15:0] bus_rdata,
   // Host to device bytes
   input wire logic host_tx_valid,
   input wire logic [7:0] host_tx_data,
   output logic host_tx_ready,
   // Device to host bytes
   input wire logic host_rx_req,
   output logic host_rx_valid,
   output logic [7:0] host_rx_data,
   output logic host_rx_flush,
   // USB state
   input wire logic usb_suspend,
   // Serial line
   output logic txd,
   input wire logic rxd,
   // Auxiliary pins
   input wire logic [10:0] aux_control_pins_in,
   output ubr_pkg::ubr_aux_s aux_control_pins
);

   // Parameter sanity, refused at elaboration
   localparam int PW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
      $error("DEPTH must be a power of two");
   end
   if (MS_CYC < 1 || LED_CYC < 1) begin : g_cyc_chk
      $error("Cycle counts must be positive");
   end

   // Half periods of the clock outputs, at least one cycle
   function automatic int half_cyc(input int hz);
      int h;
      h = ubr_pkg::CLK_HZ / (2 * hz);
      return (h < 1) ? 1 : h;
   endfunction
   localparam int H30 = half_cyc(ubr_pkg::CLK_OUT_30_HZ);
   localparam int H15 = half_cyc(ubr_pkg::CLK_OUT_15_HZ);
   localparam int H7 = half_cyc(ubr_pkg::CLK_OUT_7_HZ);

   // Combined reset: internal plus external pin
   logic rst;
   assign rst = reset | ~ext_reset_n; // [R18]

   // Software registers
   logic [13:0] baud_int; // Integer prescaler
   logic [3:0] baud_frac; // Fraction in sixteenths
   logic os_x10; // Select x10 oversampling
   logic [2:0] host_mode; // Mode from host command
   logic [2:0] ee_mode; // Mode from configuration memory
   logic [7:0] latency_ms; // Flush timeout in ms
   logic [10:0] gpio_out; // GPIO output values
   logic [10:0] gpio_dir; // GPIO direction, 1 = out
   logic [3:0] aux_func [0:10]; // Per-pin function code
   logic overrun; // Sticky receive overflow

   // Buffers
   logic [7:0] tx_mem [0:DEPTH-1]; // Host to line
   logic [7:0] rx_mem [0:DEPTH-1]; // Line to host
   logic [PW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [PW:0] tx_cnt, rx_cnt;

   // Write and read decode helpers
   logic wr_hit, rd_hit;
   assign wr_hit = bus_req.wr;
   assign rd_hit = bus_req.rd;

   // UART runs only when both sources select UART mode
   logic uart_on;
   assign uart_on = (ee_mode == 3'(ubr_pkg::UBR_MODE_UART)) // [R16]
                 && (host_mode == 3'(ubr_pkg::UBR_MODE_UART)); // [R19]

   // Control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         baud_int <= ubr_pkg::BAUD_INT_RST;
         baud_frac <= '0;
         os_x10 <= 1'b0;
         host_mode <= 3'(ubr_pkg::UBR_MODE_UART);
         ee_mode <= 3'(ubr_pkg::UBR_MODE_UART); // [R16]
         latency_ms <= ubr_pkg::LATENCY_RST; // [R7]
         gpio_out <= '0;
         gpio_dir <= '0;
      end else if (clk_en && wr_hit) begin
         case (bus_req.addr)
            ubr_pkg::REG_BAUD_INT: baud_int <= bus_req.wdata[13:0]; // [R2]
            ubr_pkg::REG_BAUD_FRAC: baud_frac <= bus_req.wdata[3:0]; // [R2]
            ubr_pkg::REG_CTRL: begin
               os_x10 <= bus_req.wdata[ubr_pkg::CTRL_X10]; // [R1]
               host_mode <= bus_req.wdata[ubr_pkg::CTRL_MODE_LSB +: 3]; // [R19]
            end
            ubr_pkg::REG_EE_MODE: ee_mode <= bus_req.wdata[2:0]; // [R16]
            ubr_pkg::REG_LATENCY: latency_ms <= bus_req.wdata[7:0]; // [R7]
            ubr_pkg::REG_GPIO_OUT: gpio_out <= bus_req.wdata[10:0]; // [R15]
            ubr_pkg::REG_GPIO_DIR: gpio_dir <= bus_req.wdata[10:0]; // [R15]
            default: ;
         endcase
      end
   end

   // Pin function table, loaded as 16-bit configuration words
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < ubr_pkg::AUX_PINS; i++)
            aux_func[i] <= 4'(ubr_pkg::UBR_AUX_INPUT_PULLUP_UNUSED);
      end else if (clk_en && wr_hit && bus_req.addr >= ubr_pkg::REG_AUX_BASE
                   && bus_req.addr < ubr_pkg::REG_AUX_BASE + 5'(ubr_pkg::AUX_PINS)) begin
         aux_func[4'(bus_req.addr - ubr_pkg::REG_AUX_BASE)]
            <= bus_req.wdata[3:0]; // [R14] [R17]
      end
   end

   // Baud generator: integer count, one extra cycle on fraction carry
   logic [13:0] div_cnt; // Cycles left in this tick
   logic [3:0] frac_acc; // Fraction accumulator
   logic os_tick; // One oversample period elapsed
   logic [4:0] frac_sum;
   assign frac_sum = {1'b0, frac_acc} + {1'b0, baud_frac};
   always_ff @(posedge clk) begin
      if (rst) begin
         div_cnt <= '0;
         frac_acc <= '0;
         os_tick <= 1'b0;
      end else if (clk_en) begin
         os_tick <= 1'b0;
         if (div_cnt == '0) begin
            os_tick <= 1'b1; // [R1]
            frac_acc <= frac_sum[3:0]; // [R2]
            // Zero divisor behaves as one; no special case for 7-11 Mbaud
            div_cnt <= ((baud_int == '0) ? 14'd0 : baud_int - 14'd1)
                       + {13'd0, frac_sum[4]}; // [R2] [R3] [R4]
         end else begin
            div_cnt <= div_cnt - 14'd1;
         end
      end
   end

   // Ticks per bit for the chosen oversampling
   logic [4:0] os_top;
   assign os_top = os_x10 ? 5'(ubr_pkg::OS_X10 - 1)
                          : 5'(ubr_pkg::OS_X16 - 1); // [R1]

   // Transmitter
   typedef enum logic [2:0] {
      UBR_TX_IDLE, UBR_TX_LEAD, UBR_TX_START, UBR_TX_DATA, UBR_TX_STOP
   } ubr_tx_e;
   ubr_tx_e tx_st;
   logic [4:0] tx_os; // Tick within bit
   logic [2:0] tx_bit; // Data bit index
   logic [7:0] tx_sh; // Shift register
   logic tx_pop; // Take byte from buffer
   logic tx_done; // Character finished, pulse
   assign tx_pop = (tx_st == UBR_TX_IDLE) && uart_on && (tx_cnt != '0) && clk_en;
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_st <= UBR_TX_IDLE;
         tx_os <= '0;
         tx_bit <= '0;
         tx_sh <= '0;
         txd <= 1'b1;
         tx_done <= 1'b0;
      end else if (clk_en) begin
         tx_done <= 1'b0;
         case (tx_st)
            UBR_TX_IDLE: begin
               txd <= 1'b1;
               if (tx_pop) begin
                  tx_sh <= tx_mem[tx_rp]; // [R5]
                  tx_os <= '0;
                  tx_st <= UBR_TX_LEAD;
               end
            end
            // One tick of enable ahead of the start bit
            UBR_TX_LEAD: if (os_tick) begin
               txd <= 1'b0; // [R20]
               tx_st <= UBR_TX_START;
            end
            UBR_TX_START: if (os_tick) begin
               if (tx_os == os_top) begin
                  tx_os <= '0;
                  tx_bit <= '0;
                  txd <= tx_sh[0];
                  tx_st <= UBR_TX_DATA;
               end else tx_os <= tx_os + 5'd1;
            end
            UBR_TX_DATA: if (os_tick) begin
               if (tx_os == os_top) begin
                  tx_os <= '0;
                  tx_sh <= {1'b0, tx_sh[7:1]};
                  if (tx_bit == 3'd7) begin
                     txd <= 1'b1;
                     tx_st <= UBR_TX_STOP;
                  end else begin
                     txd <= tx_sh[1];
                     tx_bit <= tx_bit + 3'd1;
                  end
               end else tx_os <= tx_os + 5'd1;
            end
            UBR_TX_STOP: if (os_tick) begin
               if (tx_os == os_top) begin
                  tx_os <= '0;
                  tx_done <= 1'b1;
                  tx_st <= UBR_TX_IDLE;
               end else tx_os <= tx_os + 5'd1;
            end
            default: tx_st <= UBR_TX_IDLE;
         endcase
      end
   end

   // Transmit buffer: host fills, transmitter drains
   logic tx_push;
   assign tx_push = clk_en && host_tx_valid && host_tx_ready;
   always_ff @(posedge clk) begin
      if (tx_push)
         tx_mem[tx_wp] <= host_tx_data; // [R5]
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_cnt <= '0;
         host_tx_ready <= 1'b0;
      end else if (clk_en) begin
         if (tx_push) tx_wp <= tx_wp + 1'b1;
         if (tx_pop) tx_rp <= tx_rp + 1'b1;
         tx_cnt <= tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
         // Ready drops one entry early so a push never overruns
         host_tx_ready <= (tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop))
                          < (PW+1)'(DEPTH - 1); // [R5]
      end
   end

   // Drive enable: from lead tick to end of last queued stop bit
   logic drive_en;
   always_ff @(posedge clk) begin
      if (rst) drive_en <= 1'b0;
      else if (clk_en)
         drive_en <= (tx_st != UBR_TX_IDLE) && !(tx_done && tx_cnt == '0)
                     || tx_pop; // [R8] [R20]
   end

   // Receiver: start detect, mid-bit sampling
   typedef enum logic [1:0] {
      UBR_RX_IDLE, UBR_RX_START, UBR_RX_DATA, UBR_RX_STOP
   } ubr_rx_e;
   ubr_rx_e rx_st;
   logic [4:0] rx_os;
   logic [2:0] rx_bit;
   logic [7:0] rx_sh;
   logic rx_push; // Byte complete, pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_st <= UBR_RX_IDLE;
         rx_os <= '0;
         rx_bit <= '0;
         rx_sh <= '0;
         rx_push <= 1'b0;
      end else if (clk_en) begin
         rx_push <= 1'b0;
         case (rx_st)
            UBR_RX_IDLE: if (uart_on && os_tick && !rxd) begin
               rx_os <= '0;
               rx_st <= UBR_RX_START;
            end
            // Check start level at mid bit
            UBR_RX_START: if (os_tick) begin
               if (rx_os == {1'b0, os_top[4:1]}) begin
                  rx_os <= '0;
                  rx_bit <= '0;
                  rx_st <= rxd ? UBR_RX_IDLE : UBR_RX_DATA;
               end else rx_os <= rx_os + 5'd1;
            end
            UBR_RX_DATA: if (os_tick) begin
               if (rx_os == os_top) begin
                  rx_os <= '0;
                  rx_sh <= {rxd, rx_sh[7:1]};
                  rx_bit <= rx_bit + 3'd1;
                  if (rx_bit == 3'd7) rx_st <= UBR_RX_STOP;
               end else rx_os <= rx_os + 5'd1;
            end
            // Framing errors drop the byte
            UBR_RX_STOP: if (os_tick) begin
               if (rx_os == os_top) begin
                  rx_push <= rxd; // [R6]
                  rx_st <= UBR_RX_IDLE;
               end else rx_os <= rx_os + 5'd1;
            end
            default: rx_st <= UBR_RX_IDLE;
         endcase
      end
   end

   // Receive buffer: line fills, host pops on request
   logic rx_full, rx_wr, rx_pop;
   assign rx_full = rx_cnt == (PW+1)'(DEPTH);
   assign rx_wr = clk_en && rx_push && !rx_full;
   assign rx_pop = clk_en && host_rx_req && rx_cnt != '0; // [R6]
   always_ff @(posedge clk) begin
      if (rx_wr)
         rx_mem[rx_wp] <= rx_sh; // [R6]
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_cnt <= '0;
         host_rx_valid <= 1'b0;
         host_rx_data <= '0;
      end else if (clk_en) begin
         host_rx_valid <= rx_pop;
         if (rx_pop) begin
            host_rx_data <= rx_mem[rx_rp]; // [R6]
            rx_rp <= rx_rp + 1'b1;
         end
         if (rx_wr) rx_wp <= rx_wp + 1'b1;
         rx_cnt <= rx_cnt + (PW+1)'(rx_wr) - (PW+1)'(rx_pop);
      end
   end

   // Overrun flag: set wins over the clearing status read
   always_ff @(posedge clk) begin
      if (rst) overrun <= 1'b0;
      else if (clk_en) begin
         if (rx_push && rx_full) overrun <= 1'b1;
         else if (rd_hit && bus_req.addr == ubr_pkg::REG_STATUS)
            overrun <= 1'b0;
      end
   end

   // Latency timer: flush pending data after quiet interval
   logic [$clog2(MS_CYC+1)-1:0] ms_cnt;
   logic [7:0] lat_cnt;
   always_ff @(posedge clk) begin
      if (rst) begin
         ms_cnt <= '0;
         lat_cnt <= '0;
         host_rx_flush <= 1'b0;
      end else if (clk_en) begin
         host_rx_flush <= 1'b0;
         if (rx_cnt == '0 || rx_pop) begin
            ms_cnt <= '0;
            lat_cnt <= '0;
         end else if (lat_cnt >= latency_ms) begin
            host_rx_flush <= 1'b1; // [R7]
            ms_cnt <= '0;
            lat_cnt <= '0;
         end else if (ms_cnt == ($bits(ms_cnt))'(MS_CYC - 1)) begin
            ms_cnt <= '0;
            lat_cnt <= lat_cnt + 8'd1; // [R7]
         end else ms_cnt <= ms_cnt + 1'b1;
      end
   end

   // Activity LED stretchers, active low while counting
   logic [$clog2(LED_CYC+1)-1:0] tx_led_cnt, rx_led_cnt;
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_led_cnt <= '0;
         rx_led_cnt <= '0;
      end else if (clk_en) begin
         if (tx_done) tx_led_cnt <= ($bits(tx_led_cnt))'(LED_CYC); // [R10]
         else if (tx_led_cnt != '0) tx_led_cnt <= tx_led_cnt - 1'b1;
         if (rx_push) rx_led_cnt <= ($bits(rx_led_cnt))'(LED_CYC); // [R10]
         else if (rx_led_cnt != '0) rx_led_cnt <= rx_led_cnt - 1'b1;
      end
   end

   // Clock output dividers, free running
   logic [7:0] c30_cnt, c15_cnt, c7_cnt;
   logic clock_out_thirty, clock_out_fifteen, clk7;
   always_ff @(posedge clk) begin
      if (rst) begin
         c30_cnt <= '0;
         c15_cnt <= '0;
         c7_cnt <= '0;
         clock_out_thirty <= 1'b0;
         clock_out_fifteen <= 1'b0;
         clk7 <= 1'b0;
      end else if (clk_en) begin
         c30_cnt <= (c30_cnt == 8'(H30 - 1)) ? '0 : c30_cnt + 8'd1;
         c15_cnt <= (c15_cnt == 8'(H15 - 1)) ? '0 : c15_cnt + 8'd1;
         c7_cnt <= (c7_cnt == 8'(H7 - 1)) ? '0 : c7_cnt + 8'd1;
         if (c30_cnt == 8'(H30 - 1)) clock_out_thirty <= ~clock_out_thirty; // [R12]
         if (c15_cnt == 8'(H15 - 1)) clock_out_fifteen <= ~clock_out_fifteen; // [R12]
         if (c7_cnt == 8'(H7 - 1)) clk7 <= ~clk7; // [R12]
      end
   end

   // Pin multiplexer, registered per pin
   always_ff @(posedge clk) begin
      if (rst) begin
         aux_control_pins <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < ubr_pkg::AUX_PINS; i++) begin
            aux_control_pins.oe[i] <= 1'b1;
            aux_control_pins.value[i] <= 1'b0;
            case (ubr_pkg::ubr_aux_e'(aux_func[i])) // [R14]
               ubr_pkg::UBR_AUX_DRIVE_ENABLE:
                  aux_control_pins.value[i] <= drive_en; // [R8]
               ubr_pkg::UBR_AUX_POWER_ENABLE:
                  aux_control_pins.value[i] <= usb_suspend; // [R9]
               ubr_pkg::UBR_AUX_TX_LED:
                  aux_control_pins.value[i] <= tx_led_cnt == '0; // [R10]
               ubr_pkg::UBR_AUX_RX_LED:
                  aux_control_pins.value[i] <= rx_led_cnt == '0; // [R10]
               ubr_pkg::UBR_AUX_TXRX_LED:
                  aux_control_pins.value[i]
                     <= tx_led_cnt == '0 && rx_led_cnt == '0; // [R10]
               ubr_pkg::UBR_AUX_SLEEP:
                  aux_control_pins.value[i] <= ~usb_suspend; // [R11]
               ubr_pkg::UBR_AUX_CLK_THIRTY:
                  aux_control_pins.value[i] <= clock_out_thirty; // [R12]
               ubr_pkg::UBR_AUX_CLK_FIFTEEN:
                  aux_control_pins.value[i] <= clock_out_fifteen; // [R12]
               ubr_pkg::UBR_AUX_CLK_SEVEN_HALF:
                  aux_control_pins.value[i] <= clk7; // [R12]
               ubr_pkg::UBR_AUX_DRIVE_HIGH:
                  aux_control_pins.value[i] <= 1'b1; // [R13]
               ubr_pkg::UBR_AUX_DRIVE_LOW:
                  aux_control_pins.value[i] <= 1'b0; // [R13]
               ubr_pkg::UBR_AUX_GPIO: begin
                  aux_control_pins.value[i] <= gpio_out[i]; // [R15]
                  aux_control_pins.oe[i] <= gpio_dir[i]; // [R15]
               end
               // Unused pulled-up input and unknown codes float
               default: aux_control_pins.oe[i] <= 1'b0; // [R13]
            endcase
         end
      end
   end

   // Register read data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) bus_rdata <= '0;
      else if (clk_en && rd_hit) begin
         bus_rdata <= '0;
         case (bus_req.addr)
            ubr_pkg::REG_BAUD_INT: bus_rdata <= {2'b0, baud_int};
            ubr_pkg::REG_BAUD_FRAC: bus_rdata <= {12'b0, baud_frac};
            ubr_pkg::REG_CTRL: bus_rdata <= {12'b0, host_mode, os_x10};
            ubr_pkg::REG_EE_MODE: bus_rdata <= {13'b0, ee_mode};
            ubr_pkg::REG_LATENCY: bus_rdata <= {8'b0, latency_ms};
            ubr_pkg::REG_GPIO_OUT: bus_rdata <= {5'b0, gpio_out};
            ubr_pkg::REG_GPIO_DIR: bus_rdata <= {5'b0, gpio_dir};
            ubr_pkg::REG_STATUS:
               bus_rdata <= {10'b0, overrun, drive_en, rx_full,
                             rx_cnt == '0, !host_tx_ready, tx_cnt == '0};
            ubr_pkg::REG_PIN_IN: bus_rdata <= {5'b0, aux_control_pins_in}; // [R15]
            ubr_pkg::REG_TX_LEVEL: bus_rdata <= 16'(tx_cnt);
            ubr_pkg::REG_RX_LEVEL: bus_rdata <= 16'(rx_cnt);
            default:
               if (bus_req.addr >= ubr_pkg::REG_AUX_BASE
                   && bus_req.addr < ubr_pkg::REG_AUX_BASE + 5'(ubr_pkg::AUX_PINS))
                  bus_rdata <= {12'b0,
                     aux_func[4'(bus_req.addr - ubr_pkg::REG_AUX_BASE)]};
         endcase
      end
   end

endmodule // ubr_core

`default_nettype wire

// ### bench/ubr_line.sv
// Line transceiver model on the serial side of the bridge core.
// Assumes txd loops back to rxd through the driver enable.
`timescale 1ns/100ps
`default_nettype none
module ubr_line (
   // Serial side and control pins
   input wire logic txd,
   input wire logic de,
   input wire logic off,
   output logic rxd
);
   // Driver off or powered down: bus pull-up holds idle high
   assign rxd = (de && !off) ? txd : 1'b1;
endmodule // ubr_line
`default_nettype wire

// ### bench/ubr_sva.sv
// Checker for the bridge core's pins and receive stream.
// Assumes pins 0..5 are set as enable, power, sleep, high, low, clock_out_thirty.
`timescale 1ns/100ps
`default_nettype none
module ubr_sva (
   // Clock and resets
   input wire logic clk,
   input wire logic reset,
   input wire logic ext_reset_n,
   // Watched ports
   input wire logic txd,
   input wire logic host_rx_req,
   input wire logic host_rx_valid,
   input wire logic usb_suspend,
   input wire ubr_pkg::ubr_aux_s aux_control_pins
);
   logic [10:0] v; // Pin values
   logic [10:0] e; // Pin enables
   assign v = aux_control_pins.value;
   assign e = aux_control_pins.oe;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || !ext_reset_n);
   // Start bit shortly after enable rises
   sequence start_s; ##[1:40] !txd; endsequence
   rx_pair_a: assert property (host_rx_valid |-> $past(host_rx_req))
      else $error("rx valid without request");
   de_start_a: assert property ($fell(txd) |-> e[0] && v[0])
      else $error("start bit without enable");
   de_lead_a: assert property ($rose(v[0]) |-> start_s)
      else $error("enable without character");
   power_pin_a: assert property (e[1] |-> v[1] == $past(usb_suspend))
      else $error("power pin wrong");
   sleep_pin_a: assert property (e[2] |-> v[2] == !$past(usb_suspend))
      else $error("sleep pin wrong");
   drive_high_a: assert property (e[3] |-> v[3])
      else $error("high pin low");
   drive_low_a: assert property (e[4] |-> !v[4])
      else $error("low pin high");
   clk_out_a: assert property (e[5] && $past(e[5]) |-> v[5] != $past(v[5]))
      else $error("clock pin stuck");
endmodule // ubr_sva
bind ubr_core ubr_sva u_ubr_sva (.clk, .reset, .ext_reset_n, .txd, .host_rx_req, .host_rx_valid,
   .usb_suspend, .aux_control_pins);
`default_nettype wire

// ### bench/usb_uart_baud_aux_pin_control_tb.sv
// Bench for the bridge core: registers, loopback traffic, pins.
// Assumes the line model feeds txd back to rxd.
`timescale 1ns/100ps
`default_nettype none
module usb_uart_baud_aux_pin_control_tb;
   logic clk = 1'b0; // Bench clock
   logic reset = 1'b1; // Reset, held at start
   ubr_pkg::ubr_req_s req = '0; // Register request
   logic host_tx_valid = 1'b0;
   logic [7:0] host_tx_data = 8'h00;
   logic host_rx_req = 1'b0;
   logic usb_suspend = 1'b0;
   logic ext_reset_n = 1'b1; // External reset, active low
   logic [15:0] bus_rdata;
   logic host_tx_ready, host_rx_valid, host_rx_flush, txd, rxd;
   logic [7:0] host_rx_data;
   ubr_pkg::ubr_aux_s aux_control_pins;
   logic [3:0] fn [7] = '{4'h1, 4'h2, 4'h6, 4'ha, 4'hb, 4'h7, 4'hc}; // Pin functions
   int err_total = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   ubr_core #(.MS_CYC(20), .LED_CYC(8), .DEPTH(16)) u_ubr_core (.clk, .clk_en(1'b1), .reset,
      .ext_reset_n, .bus_req(req), .bus_rdata, .host_tx_valid, .host_tx_data, .host_tx_ready,
      .host_rx_req, .host_rx_valid, .host_rx_data, .host_rx_flush, .usb_suspend, .txd, .rxd,
      .aux_control_pins_in(11'h2a5), .aux_control_pins);
   ubr_line u_ubr_line (.txd, .de(aux_control_pins.value[0]), .off(aux_control_pins.value[1]), .rxd);
   // Compare and count
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      samples_checked++;
      if (g !== x) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   // Verdict and stop
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One write cycle
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   // One read cycle, data the cycle after
   task automatic rd(input logic [4:0] a, input logic [15:0] x);
      @(posedge clk);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk("rdata", x, bus_rdata);
   endtask
   // Offer one host byte
   task automatic send(input logic [7:0] d);
      @(posedge clk);
      host_tx_valid <= 1'b1;
      host_tx_data <= d;
      #1 chk("tx_ready", 16'h0001, {15'h0, host_tx_ready});
      @(posedge clk);
      host_tx_valid <= 1'b0;
   endtask
   // Pop one received byte
   task automatic pop(input logic [7:0] x);
      @(posedge clk);
      host_rx_req <= 1'b1;
      @(posedge clk);
      host_rx_req <= 1'b0;
      #1 chk("rx_byte", {8'h01, x}, {7'h00, host_rx_valid, host_rx_data});
   endtask
   // Bounded wait for the latency flush
   task automatic wait_flush();
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge clk);
         #1 if (host_rx_flush === 1'b1) break;
      end
      chk("flush", 16'h0001, {15'h0, i < 3000});
      if (i == 3000) end_sim();
   endtask
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd(ubr_pkg::REG_BAUD_INT, 16'h001a);
      rd(ubr_pkg::REG_LATENCY, 16'h0010);
      rd(ubr_pkg::REG_EE_MODE, 16'h0000);
      rd(5'h1f, 16'h0000);
      rd(ubr_pkg::REG_PIN_IN, 16'h02a5);
      wr(ubr_pkg::REG_BAUD_FRAC, 16'h0005);
      rd(ubr_pkg::REG_BAUD_FRAC, 16'h0005);
      $display("registers done");
      foreach (fn[i]) wr(ubr_pkg::REG_AUX_BASE + 5'(i), {12'h000, fn[i]});
      wr(ubr_pkg::REG_GPIO_OUT, 16'h0040);
      wr(ubr_pkg::REG_GPIO_DIR, 16'h0040);
      wr(ubr_pkg::REG_BAUD_INT, 16'h0002);
      wr(ubr_pkg::REG_CTRL, 16'h0001);
      send(8'ha5);
      send(8'h3c);
      wait_flush();
      pop(8'ha5);
      pop(8'h3c);
      chk("de_idle", 16'h0000, {15'h0, aux_control_pins.value[0]});
      chk("pins", 16'h0006, {12'h0, aux_control_pins.value[4:1]});
      chk("gpio", 16'h0003, {14'h0, aux_control_pins.oe[6], aux_control_pins.value[6]});
      @(posedge clk);
      usb_suspend <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("suspend", 16'h0001, {14'h0, aux_control_pins.value[2:1]});
      $display("traffic done");
      for (int m = 0; m < 7; m++) begin
         wr(ubr_pkg::REG_CTRL, 16'(m * 2));
         rd(ubr_pkg::REG_CTRL, 16'(m * 2));
      end
      $display("modes done");
      // Mid-run external reset, then reset values again
      @(posedge clk);
      ext_reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      ext_reset_n <= 1'b1;
      rd(ubr_pkg::REG_CTRL, 16'h0000);
      rd(ubr_pkg::REG_BAUD_INT, 16'h001a);
      chk("pin_oe", 16'h0000, {5'h0, aux_control_pins.oe});
      $display("reset done");
      end_sim();
   end
endmodule // usb_uart_baud_aux_pin_control_tb
`default_nettype wire
